// >>> dv/rsg_bus_model.sv
// Bus partner: pull-ups, clock stretching slave and a rival master
`default_nettype none
module rsg_bus_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Pull-downs of the device and of a rival master
    input wire rsg_pkg::rsg_line_t oe_i,
    input wire logic pull_scl_i,
    input wire logic pull_sda_i,
    // Slave stretch length in cycles
    input wire logic [3:0] stretch_i,
    // Resolved wire levels
    output rsg_pkg::rsg_line_t line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsg_pkg::*;
    logic [3:0] hold_r;
    // Stretch reloads while the device holds SCL, so a slow slave keeps it low after release
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_r <= 4'h0;
        end else if (oe_i.scl) begin
            hold_r <= stretch_i;
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end
    end
    // Wired-AND with pull-ups: a released line floats high
    assign line_o.scl = !(oe_i.scl || pull_scl_i || hold_r != 4'h0);
    assign line_o.sda = !(oe_i.sda || pull_sda_i);
endmodule : rsg_bus_model
`default_nettype wire

// >>> dv/rsg_top_tb_top.sv
// Self-checking bench for the repeated start generator
`default_nettype none
module rsg_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rsg_pkg::*;
    logic mclk_i, rst_n_i, ctrl2_we_i, other_busy_i, sbuf_we_i, irq_clr_i, write_collision_flag_clr_i;
    logic bcl_clr_i, pull_scl, pull_sda, start_seen_o, irq_o, write_collision_flag_o, bcl_o, tx_start_o;
    logic [7:0] ctrl2_wdata_i, sbuf_wdata_i, ctrl2_o, sbuf_o, sbuf_exp;
    logic [BRG_W-1:0] baud_reload_i;
    logic [3:0] stretch;
    logic [1:0] line_o;
    rsg_line_t line_i, line_oe_o;
    int fail_count, compares;

    rsg_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ctrl2_we_i(ctrl2_we_i),
        .ctrl2_wdata_i(ctrl2_wdata_i), .baud_reload_i(baud_reload_i),
        .other_busy_i(other_busy_i), .sbuf_we_i(sbuf_we_i), .sbuf_wdata_i(sbuf_wdata_i),
        .irq_clr_i(irq_clr_i), .write_collision_flag_clr_i(write_collision_flag_clr_i), .bcl_clr_i(bcl_clr_i),
        .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o), .ctrl2_o(ctrl2_o),
        .sbuf_o(sbuf_o), .start_seen_o(start_seen_o), .irq_o(irq_o), .write_collision_flag_o(write_collision_flag_o),
        .bcl_o(bcl_o), .tx_start_o(tx_start_o));
    rsg_bus_model bus (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .oe_i(line_oe_o),
        .pull_scl_i(pull_scl), .pull_sda_i(pull_sda), .stretch_i(stretch), .line_o(line_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t value mismatch seen %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // Edges from the enable write to the flag: four phases plus fixed overhead
    function automatic int rs_len(input logic [6:0] rl, input logic [3:0] st);
        return 6 + rl[5:0] + 2 * rl + st;
    endfunction : rs_len

    // Mode 0 clean run with busy writes, 1 rival pulls SDA, 2 rival pulls SCL
    task automatic run_rs(input logic [6:0] rl, input logic [3:0] st, input int mode);
        int k, n_rel, n_low, want;
        want = (mode == 0) ? rs_len(rl, st) : (mode == 1) ? 4 + rl[5:0] : 6 + rl[5:0];
        n_rel = 0;
        n_low = 0;
        k = 0;
        @(posedge mclk_i);
        baud_reload_i <= rl;
        stretch <= st;
        ctrl2_we_i <= 1'b1;
        ctrl2_wdata_i <= 8'h02;
        @(posedge mclk_i);
        ctrl2_we_i <= 1'b0;
        #1;
        check(16'(ctrl2_o), 16'h02);
        while (irq_o !== 1'b1 && bcl_o !== 1'b1 && k < 700) begin
            @(posedge mclk_i);
            k++;
            sbuf_we_i <= (mode == 0 && k == 2);
            sbuf_wdata_i <= ~sbuf_exp;
            ctrl2_we_i <= (mode == 0 && k == 3);
            ctrl2_wdata_i <= 8'hfd;
            if (mode == 1 && k == 3 + rl[5:0]) pull_sda <= 1'b1;
            if (mode == 2 && k == 5 + rl[5:0]) pull_scl <= 1'b1;
            #1;
            if (k == 1) check(16'(line_oe_o.scl), 16'h1);
            n_rel += (k > 1 && line_oe_o === 2'b10);
            n_low += (irq_o === 1'b0 && line_oe_o === 2'b01);
        end
        check(16'(k), 16'(want));
        if (mode == 0) begin
            check(16'(n_rel), 16'(rl[5:0] + 1));
            check(16'(n_low), 16'(rl + 1));
            check({8'h0, ctrl2_o}, 16'h00e0);
            check(16'(line_oe_o), 16'h1);
            check({start_seen_o, write_collision_flag_o, bcl_o}, 16'h6);
            check(16'(sbuf_o), 16'(sbuf_exp));
        end else begin
            check({ctrl2_o[1], irq_o, line_oe_o}, 16'h0);
            repeat (4) @(posedge mclk_i);
            pull_sda <= 1'b0;
            pull_scl <= 1'b0;
            bcl_clr_i <= 1'b1;
            #1;
            check(16'(bcl_o), 16'h1);
            @(posedge mclk_i);
            bcl_clr_i <= 1'b0;
            #1;
            check(16'(bcl_o), 16'h0);
        end
    endtask : run_rs

    // Clears both flags; optionally hands a byte to the transmitter
    task automatic wrap_up(input logic wr, input logic [7:0] d);
        @(posedge mclk_i);
        sbuf_we_i <= wr;
        sbuf_wdata_i <= d;
        irq_clr_i <= 1'b1;
        write_collision_flag_clr_i <= 1'b1;
        @(posedge mclk_i);
        sbuf_we_i <= 1'b0;
        irq_clr_i <= 1'b0;
        write_collision_flag_clr_i <= 1'b0;
        #1;
        if (wr) begin
            sbuf_exp = d;
            check({sbuf_o, 7'h0, tx_start_o}, {d, 8'h1});
            check(16'(line_oe_o), 16'h0);
        end
        check({irq_o, write_collision_flag_o}, 16'h0);
    endtask : wrap_up

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    // Longest run is about 330 cycles, so this only trips on a hang
    initial begin
        #100000;
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        {rst_n_i, ctrl2_we_i, other_busy_i, sbuf_we_i, irq_clr_i, write_collision_flag_clr_i} = '0;
        {bcl_clr_i, pull_scl, pull_sda, ctrl2_wdata_i, sbuf_wdata_i} = '0;
        baud_reload_i = '0;
        stretch = 4'h0;
        sbuf_exp = SBUF_RST;
        fail_count = 0;
        compares = 0;
        void'($urandom(62985));
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        check({ctrl2_o, sbuf_o}, {CTRL2_RST, SBUF_RST});
        check({line_o, line_oe_o, start_seen_o, irq_o, write_collision_flag_o, bcl_o, tx_start_o}, 16'h0);
        run_rs(7'h00, 4'h0, 0);
        wrap_up(1'b1, 8'ha5);
        run_rs(7'h7f, 4'h3, 0);
        wrap_up(1'b0, 8'h00);
        for (int i = 0; i < 6; i++) begin
            run_rs(7'($urandom), 4'($urandom_range(3)), 0);
            wrap_up(1'(i), 8'($urandom));
        end
        run_rs(7'h45, 4'h0, 1);
        run_rs(7'h45, 4'h0, 2);
        @(posedge mclk_i);
        other_busy_i <= 1'b1;
        ctrl2_we_i <= 1'b1;
        ctrl2_wdata_i <= 8'h02;
        @(posedge mclk_i);
        ctrl2_we_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        #1;
        check({ctrl2_o, 6'h0, line_oe_o}, 16'h0);
        report_and_stop();
    end
endmodule : rsg_top_tb_top
`default_nettype wire

// >>> verilog/rsg_brg.sv
// Baud rate generator: loadable down counter with expiry strobe
`default_nettype none
module rsg_brg #(
    parameter int W = rsg_pkg::BRG_W
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Load
    input wire logic load_i,
    input wire logic [W-1:0] val_i,
    // Status
    output logic tick_o,
    output logic [W-1:0] cnt_o
);
    import rsg_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic run;
    } rsg_brg_st_t;

    rsg_brg_st_t s_r;
    rsg_brg_st_t s_nxt;

    // Period is val_i + 1 cycles from the load
    assign tick_o = s_r.run && (s_r.cnt == '0);
    assign cnt_o = s_r.cnt;

    always_comb begin
        s_nxt = s_r;
        if (load_i) begin
            s_nxt.cnt = val_i;
            s_nxt.run = 1'b1;
        end else if (s_r.run) begin
            // No reload on expiry; the owner decides
            if (s_r.cnt == '0) begin
                s_nxt.run = 1'b0;
            end else begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : rsg_brg
`default_nettype wire

// >>> verilog/rsg_pkg.sv
// Constants, types and state layout for the repeated start generator
`default_nettype none
package rsg_pkg;
    localparam int BRG_W = 7;
    localparam int BRG_FIRST_W = 6;
    localparam int REPEATED_START_ENABLE_BIT = 1;
    localparam int LOCK_W = 5;
    localparam int START_BIT = 3;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] SBUF_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_SCL_LOW   = 3'b001,
        ST_SDA_REL   = 3'b010,
        ST_SCL_REL   = 3'b011,
        ST_HIGH_HOLD = 3'b100,
        ST_SDA_LOW   = 3'b101,
        ST_HOLD      = 3'b110
    } rsg_fsm_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } rsg_line_t;

    typedef struct packed {
        rsg_fsm_t st;
        logic [7:0] ctrl2;
        logic [7:0] sbuf;
        rsg_line_t drv;
        rsg_line_t smp;
        logic start_seen;
        logic irq;
        logic write_collision_flag;
        logic bcl;
        logic tx_start;
    } rsg_main_t;
endpackage : rsg_pkg
`default_nettype wire

// >>> verilog/rsg_top.sv
// Master repeated start generator with flags and collision detection
`default_nettype none
// Behaviour
// - Repeated start begins only when enable bit set while master logic idle.
// - On enable, SCL is pulled low first.
// - SCL seen low: load baud counter from reload bits 5:0, start it.
// - SDA released high for exactly one baud period during that count.
// - Count expires with SDA high: release SCL.
// - SCL seen high: reload from bits 6:0; both lines high one period.
// - Then SDA pulled low one baud period while SCL high.
// - At end enable clears, no reload, SDA stays held low.
// - Start seen flag sets when a START appears on the lines.
// - Serial port flag rises only after the last baud period expires.
// - Enable written during another bus event is ignored.
// - Collision if SDA low when SCL rises during the sequence.
// - Collision if SCL falls before SDA is pulled low.
// - After the flag, buffer byte is handed to the transmitter.
// - Buffer write during sequence sets write collision, buffer kept.
// - Lower 5 control bits locked until the sequence completes.
// - Bus collision flag stays set until software clears it.
module rsg_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Control register write port
    input wire logic ctrl2_we_i,
    input wire logic [7:0] ctrl2_wdata_i,
    input wire logic [rsg_pkg::BRG_W-1:0] baud_reload_i,
    input wire logic other_busy_i,
    // Buffer write port
    input wire logic sbuf_we_i,
    input wire logic [7:0] sbuf_wdata_i,
    // Flag clears
    input wire logic irq_clr_i,
    input wire logic write_collision_flag_clr_i,
    input wire logic bcl_clr_i,
    // Bus lines, open drain
    input wire rsg_pkg::rsg_line_t line_i,
    output logic [1:0] line_o,
    output rsg_pkg::rsg_line_t line_oe_o,
    // Status
    output logic [7:0] ctrl2_o,
    output logic [7:0] sbuf_o,
    output logic start_seen_o,
    output logic irq_o,
    output logic write_collision_flag_o,
    output logic bcl_o,
    output logic tx_start_o
);
    import rsg_pkg::*;

    rsg_main_t s_r;
    rsg_main_t s_nxt;
    logic brg_load;
    logic [BRG_W-1:0] brg_val;
    logic brg_tick;
    logic [BRG_W-1:0] brg_cnt;
    logic busy;
    logic col;

    rsg_brg #(
        .W(BRG_W)
    ) u_brg (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .load_i(brg_load),
        .val_i(brg_val),
        .tick_o(brg_tick),
        .cnt_o(brg_cnt)
    );

    assign busy = (s_r.st != ST_IDLE) && (s_r.st != ST_HOLD);

    always_comb begin
        s_nxt = s_r;
        s_nxt.tx_start = 1'b0;
        s_nxt.smp = line_i;
        brg_load = 1'b0;
        brg_val = '0;
        col = 1'b0;
        // Clears first so a same-cycle event wins
        if (irq_clr_i) begin
            s_nxt.irq = 1'b0;
        end
        if (write_collision_flag_clr_i) begin
            s_nxt.write_collision_flag = 1'b0;
        end
        if (bcl_clr_i) begin
            s_nxt.bcl = 1'b0;
        end
        // Stop clears the start indication
        if (s_r.smp.scl && line_i.scl && !s_r.smp.sda && line_i.sda) begin
            s_nxt.start_seen = 1'b0;
        end
        if (s_r.smp.scl && line_i.scl && s_r.smp.sda && !line_i.sda) begin
            s_nxt.start_seen = 1'b1;
        end
        if (ctrl2_we_i) begin
            s_nxt.ctrl2[7:LOCK_W] = ctrl2_wdata_i[7:LOCK_W];
            // No event queueing, so the low bits wait for completion
            if (!busy) begin
                s_nxt.ctrl2[LOCK_W-1:0] = ctrl2_wdata_i[LOCK_W-1:0];
                if (other_busy_i) begin
                    s_nxt.ctrl2[REPEATED_START_ENABLE_BIT] = 1'b0;
                end
            end
        end
        unique case (s_r.st)
            ST_IDLE, ST_HOLD: begin
                if (s_r.ctrl2[REPEATED_START_ENABLE_BIT]) begin
                    s_nxt.drv.scl = 1'b1;
                    s_nxt.st = ST_SCL_LOW;
                end
            end
            ST_SCL_LOW: begin
                if (!line_i.scl) begin
                    brg_load = 1'b1;
                    brg_val = {1'b0, baud_reload_i[BRG_FIRST_W-1:0]};
                    s_nxt.drv.sda = 1'b0;
                    s_nxt.st = ST_SDA_REL;
                end
            end
            ST_SDA_REL: begin
                if (brg_tick) begin
                    if (line_i.sda) begin
                        s_nxt.drv.scl = 1'b0;
                        s_nxt.st = ST_SCL_REL;
                    end else begin
                        col = 1'b1;
                    end
                end
            end
            ST_SCL_REL: begin
                if (line_i.scl) begin
                    if (!line_i.sda) begin
                        col = 1'b1;
                    end else begin
                        brg_load = 1'b1;
                        brg_val = baud_reload_i;
                        s_nxt.st = ST_HIGH_HOLD;
                    end
                end
            end
            ST_HIGH_HOLD: begin
                // Low SCL here may be another master sending a one
                if (!line_i.scl || (brg_tick && !line_i.sda)) begin
                    col = 1'b1;
                end else if (brg_tick) begin
                    s_nxt.drv.sda = 1'b1;
                    brg_load = 1'b1;
                    brg_val = baud_reload_i;
                    s_nxt.st = ST_SDA_LOW;
                end
            end
            ST_SDA_LOW: begin
                if (brg_tick) begin
                    s_nxt.ctrl2[REPEATED_START_ENABLE_BIT] = 1'b0;
                    s_nxt.irq = 1'b1;
                    s_nxt.st = ST_HOLD;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        if (col) begin
            s_nxt.bcl = 1'b1;
            s_nxt.drv = '0;
            s_nxt.ctrl2[REPEATED_START_ENABLE_BIT] = 1'b0;
            s_nxt.st = ST_IDLE;
        end
        if (sbuf_we_i) begin
            if (busy) begin
                s_nxt.write_collision_flag = 1'b1;
            end else begin
                s_nxt.sbuf = sbuf_wdata_i;
                s_nxt.tx_start = 1'b1;
                // Transmitter takes the data line over from here
                if (s_nxt.st == ST_HOLD) begin
                    s_nxt.drv.sda = 1'b0;
                    s_nxt.st = ST_IDLE;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r.st <= ST_IDLE;
            s_r.ctrl2 <= CTRL2_RST;
            s_r.sbuf <= SBUF_RST;
            s_r.drv <= '0;
            s_r.smp <= '1;
            s_r.start_seen <= 1'b0;
            s_r.irq <= 1'b0;
            s_r.write_collision_flag <= 1'b0;
            s_r.bcl <= 1'b0;
            s_r.tx_start <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Open drain: value is always low, enable does the work
    assign line_o = 2'b00;
    assign line_oe_o = s_r.drv;
    assign ctrl2_o = s_r.ctrl2;
    assign sbuf_o = s_r.sbuf;
    assign start_seen_o = s_r.start_seen;
    assign irq_o = s_r.irq;
    assign write_collision_flag_o = s_r.write_collision_flag;
    assign bcl_o = s_r.bcl;
    assign tx_start_o = s_r.tx_start;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_idle_start;
        (s_r.st == ST_SCL_LOW && $past(s_r.st) != ST_SCL_LOW)
            |-> ($past(s_r.st) == ST_IDLE || $past(s_r.st) == ST_HOLD) && $past(ctrl2_o[1]);
    endproperty
    a_idle_start: assert property (p_idle_start) else $error("start left non-idle state");

    property p_scl_first;
        (s_r.st == ST_SCL_LOW && $past(s_r.st) != ST_SCL_LOW) |-> line_oe_o.scl;
    endproperty
    a_scl_first: assert property (p_scl_first) else $error("SCL not pulled low first");

    property p_first_load;
        (s_r.st == ST_SCL_LOW && !line_i.scl)
            |=> brg_cnt == {1'b0, $past(baud_reload_i[5:0])} && s_r.st == ST_SDA_REL;
    endproperty
    a_first_load: assert property (p_first_load) else $error("first baud load wrong");

    property p_sda_rel;
        $rose(s_r.st == ST_SDA_REL) |-> !line_oe_o.sda throughout (##[1:64] s_r.st != ST_SDA_REL);
    endproperty
    a_sda_rel: assert property (p_sda_rel) else $error("SDA release phase wrong");

    property p_scl_rel;
        (s_r.st == ST_SDA_REL && brg_tick && line_i.sda) |=> !line_oe_o.scl && s_r.st == ST_SCL_REL;
    endproperty
    a_scl_rel: assert property (p_scl_rel) else $error("SCL not released");

    property p_high_load;
        (s_r.st == ST_SCL_REL && line_i.scl && line_i.sda)
            |=> brg_cnt == $past(baud_reload_i) && !line_oe_o.sda && !line_oe_o.scl;
    endproperty
    a_high_load: assert property (p_high_load) else $error("high phase load wrong");

    property p_sda_low;
        s_r.st == ST_SDA_LOW |-> line_oe_o.sda && !line_oe_o.scl;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("SDA low phase wrong");

    property p_end;
        (s_r.st == ST_SDA_LOW && brg_tick) |=> !ctrl2_o[1] && line_oe_o.sda && irq_o && !brg_tick;
    endproperty
    a_end: assert property (p_end) else $error("sequence end wrong");

    property p_start_seen;
        (s_r.smp.scl && line_i.scl && s_r.smp.sda && !line_i.sda) |=> start_seen_o;
    endproperty
    a_start_seen: assert property (p_start_seen) else $error("start not flagged");

    property p_irq_late;
        $rose(irq_o) |-> $past(s_r.st) == ST_SDA_LOW && $past(brg_tick);
    endproperty
    a_irq_late: assert property (p_irq_late) else $error("flag raised early");

    property p_ignore;
        (ctrl2_we_i && other_busy_i && !ctrl2_o[1] && !irq_clr_i) |=> !ctrl2_o[1];
    endproperty
    a_ignore: assert property (p_ignore) else $error("enable taken while bus busy");

    property p_col_rise;
        (s_r.st == ST_SCL_REL && line_i.scl && !line_i.sda) |=> bcl_o && s_r.st == ST_IDLE;
    endproperty
    a_col_rise: assert property (p_col_rise) else $error("rise collision missed");

    property p_col_scl;
        (s_r.st == ST_HIGH_HOLD && !line_i.scl) |=> bcl_o && line_oe_o == '0;
    endproperty
    a_col_scl: assert property (p_col_scl) else $error("SCL collision missed");

    property p_tx;
        (sbuf_we_i && !busy) |=> tx_start_o && sbuf_o == $past(sbuf_wdata_i);
    endproperty
    a_tx: assert property (p_tx) else $error("buffer hand-off wrong");

    property p_write_collision_flag;
        (sbuf_we_i && busy) |=> write_collision_flag_o && $stable(sbuf_o) && !tx_start_o;
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("write collision wrong");

    // Enable bit may still be cleared by hardware, so it is only kept from rising
    property p_lock;
        (ctrl2_we_i && busy)
            |=> $stable(ctrl2_o[4:2]) && $stable(ctrl2_o[0]) && !$rose(ctrl2_o[1]);
    endproperty
    a_lock: assert property (p_lock) else $error("low bits written while busy");

    property p_bcl_sticky;
        (bcl_o && !bcl_clr_i) |=> bcl_o;
    endproperty
    a_bcl_sticky: assert property (p_bcl_sticky) else $error("collision flag dropped");

    c_done: cover property ((s_r.st == ST_SDA_LOW && brg_tick) ##1 irq_o);
    c_col: cover property ($rose(bcl_o));
    c_write_collision_flag: cover property ($rose(write_collision_flag_o));
    c_tx: cover property (s_r.st == ST_HOLD ##[1:20] tx_start_o);
endmodule : rsg_top
`default_nettype wire
